// ===== hw/tcr_pkg.sv
// constants shared by the timer control/capture/reload block
package tcr_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] TCR_SFR_PAGE = 8'h10;
    localparam logic [7:0] TCR_ADDR_TIMER_A_CONTROL = 8'hc8;
    localparam logic [7:0] TCR_ADDR_TIMER_B_CONTROL = 8'h91;
    localparam logic [7:0] TCR_CTL_RESET = 8'h00;
    localparam logic [7:0] TCR_RDATA_UNMAPPED = 8'h00;
    // ------------------------------------------------------------
    // control register field positions
    // ------------------------------------------------------------
    localparam int TCR_BIT_WRAP_FLAG = 7;
    localparam int TCR_BIT_EXT_EVENT_FLAG = 6;
    localparam int TCR_BIT_EXT_PIN_ENABLE = 3;
    localparam int TCR_BIT_RUN_CONTROL = 2;
    localparam int TCR_BIT_COUNT_SOURCE_SELECT = 1;
    localparam int TCR_BIT_CAPTURE_RELOAD_SELECT = 0;
    // ------------------------------------------------------------
    // count values
    // ------------------------------------------------------------
    localparam logic [15:0] TCR_COUNT_MAX = 16'hffff;
    localparam logic [15:0] TCR_COUNT_ZERO = 16'h0000;
    localparam logic [15:0] TCR_COUNT_RESET = 16'h0000;
    localparam logic [15:0] TCR_CRV_RESET = 16'h0000;
    // ------------------------------------------------------------
    // clock prescale select codes and divide counts
    // ------------------------------------------------------------
    localparam logic [1:0] TCR_PS_DIV1 = 2'h0;
    localparam logic [1:0] TCR_PS_DIV2 = 2'h1;
    localparam logic [1:0] TCR_PS_DIV12 = 2'h2;
    localparam logic [1:0] TCR_PS_EXT_DIV8 = 2'h3;
    localparam logic [3:0] TCR_DIV2_COUNT = 4'h2;
    localparam logic [3:0] TCR_DIV12_COUNT = 4'hc;
    localparam logic [3:0] TCR_EXT_DIV8_COUNT = 4'h8;
    localparam logic [3:0] TCR_PS_RESET = 4'h0;
    localparam logic [2:0] TCR_SYNC_RESET = 3'h0;
endpackage

// ===== hw/tcr_timer.sv
// one 16-bit up/down timer with capture/reload register and prescaler
`timescale 1ns/1ns
module tcr_timer
    import tcr_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic run_control, // timer runs when high
    input wire logic count_source_select, // 1: count pin falling edges
    input wire logic capture_reload_select, // 1: capture, 0: auto-reload
    input wire logic ext_pin_enable, // pin may trigger/steer
    input wire logic down_count_enable, // pin level sets direction
    input wire logic [1:0] clock_prescale_select, // timer clock choice
    input wire logic pin_level, // synchronised trigger pin level
    input wire logic pin_fall, // one pulse per falling edge
    input wire logic ext_tick, // one pulse per external clock rising edge
    input wire logic crv_wr, // software load of capture/reload value
    input wire logic [15:0] crv_wdata, // value for crv_wr
    output logic [15:0] count, // current count
    output logic [15:0] crv, // capture/reload value
    output logic wrap_evt, // pulse: wrap happened
    output logic ext_evt // pulse: pin caused capture or reload
);
    import tcr_pkg::*;

    logic [3:0] ps_cnt, next_ps_cnt;
    logic [15:0] next_count, next_crv;
    logic next_wrap_evt, next_ext_evt;
    logic ps_tick, step, tick, trig_ok, count_up;
    logic [3:0] ps_lim;

    // ------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------
    always_comb begin
        ps_tick = 1'b0;
        next_ps_cnt = ps_cnt;
        step = (clock_prescale_select == TCR_PS_EXT_DIV8) ? ext_tick : 1'b1;
        case (clock_prescale_select)
            TCR_PS_DIV2: ps_lim = TCR_DIV2_COUNT;
            TCR_PS_DIV12: ps_lim = TCR_DIV12_COUNT;
            TCR_PS_EXT_DIV8: ps_lim = TCR_EXT_DIV8_COUNT;
            default: ps_lim = TCR_DIV2_COUNT;
        endcase
        if (!run_control) begin
            next_ps_cnt = TCR_PS_RESET;
        end else if (clock_prescale_select == TCR_PS_DIV1) begin
            ps_tick = 1'b1;
        end else if (step) begin
            // a smaller divisor chosen mid-count must not wait for wraparound
            if (ps_cnt >= ps_lim - 4'h1) begin
                next_ps_cnt = TCR_PS_RESET;
                ps_tick = 1'b1;
            end else begin
                next_ps_cnt = ps_cnt + 4'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // count, capture and reload
    // ------------------------------------------------------------
    always_comb begin
        next_count = count;
        next_crv = crv;
        next_wrap_evt = 1'b0;
        next_ext_evt = 1'b0;
        // with down-count on, the pin only steers and never triggers
        trig_ok = pin_fall && ext_pin_enable && !down_count_enable;
        count_up = !(down_count_enable && ext_pin_enable && !pin_level);
        tick = run_control && (count_source_select ? pin_fall : ps_tick);
        if (crv_wr) begin
            next_crv = crv_wdata;
        end
        if (tick) begin
            if (count_up) begin
                if (count == TCR_COUNT_MAX) begin
                    next_wrap_evt = 1'b1;
                    next_count = capture_reload_select ? TCR_COUNT_ZERO : crv;
                end else begin
                    next_count = count + 16'h0001;
                end
            end else if (!capture_reload_select && count == crv) begin
                next_wrap_evt = 1'b1;
                next_count = TCR_COUNT_MAX;
            end else if (capture_reload_select && count == TCR_COUNT_ZERO) begin
                next_wrap_evt = 1'b1;
                next_count = TCR_COUNT_MAX;
            end else begin
                next_count = count - 16'h0001;
            end
        end
        // a pin reload outranks the count step; a pin capture outranks a software load
        if (trig_ok) begin
            next_ext_evt = 1'b1;
            if (capture_reload_select) begin
                next_crv = count;
            end else begin
                next_count = crv;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ps_cnt <= TCR_PS_RESET;
            count <= TCR_COUNT_RESET;
            crv <= TCR_CRV_RESET;
            wrap_evt <= 1'b0;
            ext_evt <= 1'b0;
        end else begin
            ps_cnt <= next_ps_cnt;
            count <= next_count;
            crv <= next_crv;
            wrap_evt <= next_wrap_evt;
            ext_evt <= next_ext_evt;
        end
    end
endmodule

// ===== hw/tcr_top.sv
// control registers, pin sampling and checks for two up/down timers
//
// What this block does
// - up-count rollover from all ones sets wrap flag
// - reload-mode down match sets flag, loads all ones
// - capture-mode down from zero sets wrap flag
// - set wrap flag raises enabled interrupt request
// - flags cleared only by software writes
// - pin falling edge capture/reload sets event flag
// - pin neither triggers nor steers while pin enable is clear
// - capture mode falling edge copies count
// - reload mode falling edge reloads, sets flag
// - down-count on: pin level steers, no reload
// - run control stops or runs the timer
// - source zero counts the prescaled clock
// - source one counts pin falling edges
// - mode bit picks reload or capture
// - control registers at 0xc8 and 0x91, page 0x10
// - with down-count and pin enable on, pin high counts up, low counts down
// - up overflow in reload mode loads reload value
`timescale 1ns/1ns
module tcr_top
    import tcr_pkg::*;
(
    input wire logic clk, // system clock, 100 MHz
    input wire logic rst_n, // async reset, active low
    input wire logic [7:0] sfr_page, // register page select
    input wire logic [7:0] sfr_addr, // register address
    input wire logic sfr_wr, // byte write strobe
    input wire logic [7:0] sfr_wdata, // byte write data
    input wire logic sfr_bit_wr, // single-bit write strobe
    input wire logic [2:0] sfr_bit_sel, // bit number for sfr_bit_wr
    input wire logic sfr_bit_val, // bit value for sfr_bit_wr
    input wire logic sfr_rd, // read strobe
    output logic [7:0] sfr_rdata, // read data, one cycle after sfr_rd
    input wire logic ext_trigger_pin_a, // timer a trigger pin
    input wire logic ext_trigger_pin_b, // timer b trigger pin
    input wire logic ext_clk_pin, // external clock for divide-by-8
    input wire logic down_count_enable_a, // timer a down-count enable
    input wire logic down_count_enable_b, // timer b down-count enable
    input wire logic [1:0] clock_prescale_select_a, // timer a clock choice
    input wire logic [1:0] clock_prescale_select_b, // timer b clock choice
    input wire logic irq_enable_a, // timer a interrupt enable
    input wire logic irq_enable_b, // timer b interrupt enable
    input wire logic crv_wr_a, // load timer a capture/reload value
    input wire logic [15:0] crv_wdata_a, // value for crv_wr_a
    input wire logic crv_wr_b, // load timer b capture/reload value
    input wire logic [15:0] crv_wdata_b, // value for crv_wr_b
    output logic irq_a, // timer a interrupt request
    output logic irq_b, // timer b interrupt request
    output logic [15:0] count_a, // timer a count
    output logic [15:0] count_b, // timer b count
    output logic [15:0] crv_a, // timer a capture/reload value
    output logic [15:0] crv_b // timer b capture/reload value
);
    import tcr_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // stage 3 exists only for edge detection so stage 1 feeds nothing else
    logic [2:0] pin_s1, pin_s2, pin_s3;
    logic [1:0] pin_fall;
    logic ext_tick;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1 <= TCR_SYNC_RESET;
            pin_s2 <= TCR_SYNC_RESET;
            pin_s3 <= TCR_SYNC_RESET;
        end else begin
            pin_s1 <= {ext_clk_pin, ext_trigger_pin_b, ext_trigger_pin_a};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    assign pin_fall = pin_s3[1:0] & ~pin_s2[1:0];
    assign ext_tick = pin_s2[2] & ~pin_s3[2];

    // ------------------------------------------------------------
    // control registers and read port
    // ------------------------------------------------------------
    logic [1:0][7:0] ctl, next_ctl;
    logic [1:0] hit, wrap_evt, ext_evt, irq_enable, down_en, irq, next_irq;
    logic [7:0] next_rdata, bit_data;
    logic page_ok;

    assign irq_enable = {irq_enable_b, irq_enable_a};
    assign down_en = {down_count_enable_b, down_count_enable_a};

    always_comb begin
        page_ok = (sfr_page == TCR_SFR_PAGE);
        hit[0] = page_ok && (sfr_addr == TCR_ADDR_TIMER_A_CONTROL);
        hit[1] = page_ok && (sfr_addr == TCR_ADDR_TIMER_B_CONTROL);
        bit_data = ctl[0];
        bit_data[sfr_bit_sel] = sfr_bit_val;
        next_ctl = ctl;
        // byte write wins over a bit write; only timer a is bit-addressable
        if (hit[0] && sfr_wr) begin
            next_ctl[0] = sfr_wdata;
        end else if (hit[0] && sfr_bit_wr) begin
            next_ctl[0] = bit_data;
        end
        if (hit[1] && sfr_wr) begin
            next_ctl[1] = sfr_wdata;
        end
        // hardware set lands after the write, so a set beats a clear
        for (int i = 0; i < 2; i++) begin
            if (wrap_evt[i]) begin
                next_ctl[i][TCR_BIT_WRAP_FLAG] = 1'b1;
            end
            if (ext_evt[i]) begin
                next_ctl[i][TCR_BIT_EXT_EVENT_FLAG] = 1'b1;
            end
            next_irq[i] = ctl[i][TCR_BIT_WRAP_FLAG] && irq_enable[i];
        end
        next_rdata = sfr_rdata;
        if (sfr_rd) begin
            next_rdata = hit[0] ? ctl[0] : (hit[1] ? ctl[1] : TCR_RDATA_UNMAPPED);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl <= {TCR_CTL_RESET, TCR_CTL_RESET};
            irq <= 2'h0;
            sfr_rdata <= TCR_RDATA_UNMAPPED;
        end else begin
            ctl <= next_ctl;
            irq <= next_irq;
            sfr_rdata <= next_rdata;
        end
    end

    assign irq_a = irq[0];
    assign irq_b = irq[1];

    // ------------------------------------------------------------
    // timers
    // ------------------------------------------------------------
    logic [1:0][1:0] ps_sel;
    logic [1:0][15:0] cnt, crv_val, crv_wdata;
    logic [1:0] crv_wr;

    assign ps_sel = {clock_prescale_select_b, clock_prescale_select_a};
    assign crv_wdata = {crv_wdata_b, crv_wdata_a};
    assign crv_wr = {crv_wr_b, crv_wr_a};

    for (genvar g = 0; g < 2; g++) begin : g_timer
        tcr_timer u_timer (
            .clk(clk),
            .rst_n(rst_n),
            .run_control(ctl[g][TCR_BIT_RUN_CONTROL]),
            .count_source_select(ctl[g][TCR_BIT_COUNT_SOURCE_SELECT]),
            .capture_reload_select(ctl[g][TCR_BIT_CAPTURE_RELOAD_SELECT]),
            .ext_pin_enable(ctl[g][TCR_BIT_EXT_PIN_ENABLE]),
            .down_count_enable(down_en[g]),
            .clock_prescale_select(ps_sel[g]),
            .pin_level(pin_s2[g]),
            .pin_fall(pin_fall[g]),
            .ext_tick(ext_tick),
            .crv_wr(crv_wr[g]),
            .crv_wdata(crv_wdata[g]),
            .count(cnt[g]),
            .crv(crv_val[g]),
            .wrap_evt(wrap_evt[g]),
            .ext_evt(ext_evt[g])
        );
    end

    assign count_a = cnt[0];
    assign count_b = cnt[1];
    assign crv_a = crv_val[0];
    assign crv_b = crv_val[1];

    // ------------------------------------------------------------
    // checks on timer a
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    logic a_up, a_trig, a_capture, a_ext_pin_enable, a_run, a_wr;
    assign a_capture = ctl[0][TCR_BIT_CAPTURE_RELOAD_SELECT];
    assign a_ext_pin_enable = ctl[0][TCR_BIT_EXT_PIN_ENABLE];
    assign a_run = ctl[0][TCR_BIT_RUN_CONTROL];
    assign a_up = !(down_count_enable_a && a_ext_pin_enable && !pin_s2[0]);
    assign a_trig = pin_fall[0] && a_ext_pin_enable && !down_count_enable_a;
    assign a_wr = hit[0] && (sfr_wr || sfr_bit_wr);

    sequence s_pin_trig;
        a_trig;
    endsequence

    sequence s_flag_set_late;
        ext_evt[0] ##1 ctl[0][TCR_BIT_EXT_EVENT_FLAG];
    endsequence

    AST_WRAP_UP_FLAG: assert property (
        (a_run && a_up && !a_trig && !ctl[0][TCR_BIT_COUNT_SOURCE_SELECT]
            && ps_sel[0] == TCR_PS_DIV1 && cnt[0] == TCR_COUNT_MAX)
        |=> wrap_evt[0] ##1 ctl[0][TCR_BIT_WRAP_FLAG])
        else $error("up rollover did not set wrap flag");

    AST_DOWN_RELOAD_LOAD: assert property (
        (wrap_evt[0] && !$past(a_up) && !$past(a_capture) && !$past(a_trig))
        |-> cnt[0] == TCR_COUNT_MAX)
        else $error("reload-mode underflow did not load all ones");

    AST_CAPTURE_DOWN_WRAP: assert property (
        (a_run && !a_up && a_capture && cnt[0] == TCR_COUNT_ZERO
            && ps_sel[0] == TCR_PS_DIV1 && !ctl[0][TCR_BIT_COUNT_SOURCE_SELECT])
        |=> wrap_evt[0] && cnt[0] == TCR_COUNT_MAX)
        else $error("capture-mode underflow missed");

    AST_IRQ_FOLLOWS_FLAG: assert property (
        (ctl[0][TCR_BIT_WRAP_FLAG] && irq_enable_a) |=> irq_a)
        else $error("interrupt request not raised for wrap flag");

    AST_FLAG_STICKY: assert property (
        (ctl[0][TCR_BIT_WRAP_FLAG] && !a_wr) |=> ctl[0][TCR_BIT_WRAP_FLAG])
        else $error("wrap flag cleared without a write");

    AST_EXT_FLAG: assert property (
        s_pin_trig |=> s_flag_set_late)
        else $error("pin event did not set external event flag");

    AST_PIN_IGNORED: assert property (
        (!a_ext_pin_enable) |=> !ext_evt[0])
        else $error("pin acted while pin enable was clear");

    AST_CAPTURE_COPY: assert property (
        (a_trig && a_capture && !crv_wr_a) |=> crv_val[0] == $past(cnt[0]))
        else $error("capture did not copy the count");

    AST_PIN_RELOAD: assert property (
        (a_trig && !a_capture) |=> cnt[0] == $past(crv_val[0]))
        else $error("pin reload did not load reload value");

    AST_STOPPED_HOLD: assert property (
        (!a_run && !a_trig) |=> $stable(cnt[0]))
        else $error("count moved while stopped");

    AST_UP_RELOAD: assert property (
        (wrap_evt[0] && $past(a_up) && !$past(a_capture) && !$past(a_trig))
        |-> cnt[0] == $past(crv_val[0]))
        else $error("up overflow did not load reload value");

    // ------------------------------------------------------------
    // checks on timer b and the read port
    // ------------------------------------------------------------
    logic b_trig, b_capture, b_wr;
    assign b_trig = pin_fall[1] && ctl[1][TCR_BIT_EXT_PIN_ENABLE] && !down_count_enable_b;
    assign b_capture = ctl[1][TCR_BIT_CAPTURE_RELOAD_SELECT];
    // timer b has no single-bit write, so only the byte strobe may clear it
    assign b_wr = hit[1] && sfr_wr;

    sequence s_b_pin_trig;
        b_trig;
    endsequence

    sequence s_b_flag_set_late;
        ext_evt[1] ##1 ctl[1][TCR_BIT_EXT_EVENT_FLAG];
    endsequence

    AST_B_EXT_FLAG: assert property (
        s_b_pin_trig |=> s_b_flag_set_late)
        else $error("timer b pin event did not set external event flag");

    AST_B_CAPTURE_COPY: assert property (
        (b_trig && b_capture && !crv_wr_b) |=> crv_val[1] == $past(cnt[1]))
        else $error("timer b capture did not copy the count");

    AST_B_PIN_IGNORED: assert property (
        (!ctl[1][TCR_BIT_EXT_PIN_ENABLE]) |=> !ext_evt[1])
        else $error("timer b pin acted while pin enable was clear");

    AST_B_FLAG_STICKY: assert property (
        (ctl[1][TCR_BIT_EXT_EVENT_FLAG] && !b_wr) |=> ctl[1][TCR_BIT_EXT_EVENT_FLAG])
        else $error("timer b event flag cleared without a write");

    AST_B_IRQ_MASKED: assert property (
        (!irq_enable_b) |=> !irq_b)
        else $error("timer b interrupt raised while disabled");

    AST_B_BIT_WRITE_IGNORED: assert property (
        (hit[1] && sfr_bit_wr && !sfr_wr && !wrap_evt[1] && !ext_evt[1])
        |=> $stable(ctl[1]))
        else $error("single-bit write changed timer b register");

    AST_READ_B: assert property (
        (sfr_rd && hit[1]) |=> sfr_rdata == $past(ctl[1]))
        else $error("read data does not match timer b register");
endmodule

// ===== bench/tcr_pin_drv.sv
// board-side driver for the two timer trigger pins
`timescale 1ns/1ns
module tcr_pin_drv (
    input wire logic clk, // system clock
    output logic pin_a, // timer a trigger pin
    output logic pin_b // timer b trigger pin
);
    // pins are always driven to a solid digital level, never left floating
    initial begin
        pin_a = 1'b1;
        pin_b = 1'b1;
    end
    // each level is held 4 cycles so the two-flop synchroniser sees it
    task automatic level(input int i, input logic v);
        @(posedge clk);
        if (i == 0) begin
            pin_a <= v;
        end else begin
            pin_b <= v;
        end
        repeat (4) @(posedge clk);
    endtask
    task automatic fall(input int i);
        level(i, 1'b1);
        level(i, 1'b0);
    endtask
endmodule

// ===== bench/tb_tcr_top.sv
// self-checking bench for the dual timer control block
`timescale 1ns/1ns
module tb_tcr_top;
    import tcr_pkg::*;
    logic clk, rst_n, sfr_wr, sfr_bit_wr, sfr_bit_val, sfr_rd, ext_clk_pin, pin_a, pin_b;
    logic [7:0] sfr_page, sfr_addr, sfr_wdata, sfr_rdata;
    logic [2:0] sfr_bit_sel;
    logic dcen_a, dcen_b, irq_en_a, irq_en_b, crv_wr_a, crv_wr_b, irq_a, irq_b;
    logic [1:0] ps_a, ps_b;
    logic [15:0] crv_wdata_a, crv_wdata_b, count_a, count_b, crv_a, crv_b, c0;
    logic [31:0] seed;
    int failures, n_checks, n;
    int model_ctl[2];
    int span[4] = '{8, 24, 48, 64};
    int rate[4] = '{8, 12, 4, 4};

    tcr_top dut (.clk(clk), .rst_n(rst_n), .sfr_page(sfr_page), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_bit_wr(sfr_bit_wr),
        .sfr_bit_sel(sfr_bit_sel), .sfr_bit_val(sfr_bit_val), .sfr_rd(sfr_rd),
        .sfr_rdata(sfr_rdata), .ext_trigger_pin_a(pin_a), .ext_trigger_pin_b(pin_b),
        .ext_clk_pin(ext_clk_pin), .down_count_enable_a(dcen_a), .down_count_enable_b(dcen_b),
        .clock_prescale_select_a(ps_a), .clock_prescale_select_b(ps_b),
        .irq_enable_a(irq_en_a), .irq_enable_b(irq_en_b), .crv_wr_a(crv_wr_a),
        .crv_wdata_a(crv_wdata_a), .crv_wr_b(crv_wr_b), .crv_wdata_b(crv_wdata_b),
        .irq_a(irq_a), .irq_b(irq_b), .count_a(count_a), .count_b(count_b),
        .crv_a(crv_a), .crv_b(crv_b));
    tcr_pin_drv u_pin (.clk(clk), .pin_a(pin_a), .pin_b(pin_b));

    // ------------------------------------------------------------
    // clocks, helpers and the register model
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // external clock: one rising edge every two system cycles
    always @(posedge clk) ext_clk_pin <= ~ext_clk_pin;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] addr_of(input int i);
        return (i == 0) ? TCR_ADDR_TIMER_A_CONTROL : (i == 1) ? TCR_ADDR_TIMER_B_CONTROL : 8'h55;
    endfunction
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic wr(input int i, input logic [7:0] d, input logic [7:0] pg = TCR_SFR_PAGE);
        @(posedge clk);
        sfr_page <= pg;
        sfr_addr <= addr_of(i);
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clk);
        sfr_wr <= 1'b0;
        if (pg == TCR_SFR_PAGE && i < 2) model_ctl[i] = int'(d);
    endtask
    // single-bit writes only exist at the timer a register
    task automatic bwr(input int i, input int b, input logic v);
        @(posedge clk);
        sfr_page <= TCR_SFR_PAGE;
        sfr_addr <= addr_of(i);
        sfr_bit_sel <= 3'(b);
        sfr_bit_val <= v;
        sfr_bit_wr <= 1'b1;
        @(posedge clk);
        sfr_bit_wr <= 1'b0;
        if (i == 0) model_ctl[0][b] = v;
    endtask
    task automatic rd(input int i, input string what);
        @(posedge clk);
        sfr_page <= TCR_SFR_PAGE;
        sfr_addr <= addr_of(i);
        sfr_rd <= 1'b1;
        @(posedge clk);
        sfr_rd <= 1'b0;
        #1;
        check(what, {8'h00, sfr_rdata}, (i < 2) ? model_ctl[i][15:0] : 16'h0000);
    endtask
    task automatic cw(input int i, input logic [15:0] v);
        @(posedge clk);
        crv_wdata_a <= v;
        crv_wdata_b <= v;
        crv_wr_a <= (i == 0);
        crv_wr_b <= (i == 1);
        @(posedge clk);
        crv_wr_a <= 1'b0;
        crv_wr_b <= 1'b0;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        close_out();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 32'd84;
        rst_n = 1'b0;
        {sfr_wr, sfr_bit_wr, sfr_bit_val, sfr_rd, ext_clk_pin} = '0;
        {sfr_page, sfr_addr, sfr_wdata, sfr_bit_sel} = '0;
        {dcen_a, dcen_b, irq_en_a, irq_en_b, crv_wr_a, crv_wr_b, ps_a, ps_b} = '0;
        {crv_wdata_a, crv_wdata_b} = '0;
        model_ctl = '{0, 0};
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rd(0, "ctl_a reset");
        rd(1, "ctl_b reset");
        wr(0, 8'hff, 8'h11);
        wr(2, 8'hff);
        rd(0, "ctl_a other page");
        rd(2, "unmapped");
        bwr(0, 2, 1'b1);
        bwr(1, 2, 1'b1);
        rd(0, "ctl_a bit write");
        rd(1, "ctl_b bit write");
        wr(1, 8'(rnd()) & 8'h30);
        rd(1, "ctl_b reserved bits");
        // every prescale code, tolerance of one for the divider phase
        for (int p = 0; p < 4; p++) begin
            ps_a <= 2'(p);
            wr(0, 8'h04);
            cyc(20);
            c0 = count_a;
            cyc(span[p]);
            n = int'(16'(count_a - c0));
            check("prescale rate", 16'(n >= rate[p] - 1 && n <= rate[p] + 1), 16'h1);
        end
        wr(0, 8'h00);
        ps_a <= 2'h0;
        cyc(2);
        c0 = count_a;
        cyc(10);
        check("stopped count", count_a, c0);
        // pin reload, then overflow reloads from the capture/reload value
        irq_en_a <= 1'b1;
        cw(0, 16'hfff0);
        wr(0, 8'h0c);
        u_pin.fall(0);
        cyc(40);
        model_ctl[0] = 32'hcc;
        rd(0, "ctl_a reload wrap");
        check("reload base", 16'(count_a >= 16'hfff0), 16'h1);
        check("irq a", 16'(irq_a), 16'h1);
        check("crv a kept", crv_a, 16'hfff0);
        cyc(40);
        rd(0, "ctl_a flags held");
        wr(0, 8'h0d);
        u_pin.fall(0);
        cyc(30);
        model_ctl[0] = 32'hcd;
        rd(0, "ctl_a up wrap and capture");
        check("wrap to zero", 16'(count_a < 16'h0040), 16'h1);
        wr(0, 8'h08);
        cyc(3);
        check("irq a cleared", 16'(irq_a), 16'h0);
        // capture mode counting down: zero passes to all ones
        dcen_a <= 1'b1;
        wr(0, 8'h0d);
        cyc(80);
        model_ctl[0] = 32'h8d;
        rd(0, "ctl_a capture down wrap");
        check("capture down ones", 16'(count_a >= 16'hff00), 16'h1);
        wr(0, 8'h08);
        // down count in reload mode: match with the reload value loads all ones
        cw(0, count_a - 16'h0008);
        dcen_a <= 1'b1;
        wr(0, 8'h0c);
        cyc(20);
        model_ctl[0] = 32'h8c;
        rd(0, "ctl_a down match");
        check("underflow load", 16'(count_a >= 16'hffd0), 16'h1);
        u_pin.level(0, 1'b1);
        cyc(2);
        c0 = count_a;
        cyc(4);
        check("count up", count_a - c0, 16'h0004);
        u_pin.level(0, 1'b0);
        cyc(2);
        c0 = count_a;
        cyc(4);
        check("count down", c0 - count_a, 16'h0004);
        rd(0, "no pin event with down count");
        wr(0, 8'h00);
        dcen_a <= 1'b0;
        // timer b: capture-mode underflow, masked interrupt, capture
        dcen_b <= 1'b1;
        u_pin.level(1, 1'b0);
        wr(1, 8'h0d);
        cyc(20);
        model_ctl[1] = 32'h8d;
        rd(1, "ctl_b down wrap");
        check("underflow to ones", 16'(count_b >= 16'hffe0), 16'h1);
        check("irq b masked", 16'(irq_b), 16'h0);
        dcen_b <= 1'b0;
        wr(1, 8'h09);
        cyc(1);
        c0 = count_b;
        u_pin.fall(1);
        cyc(2);
        model_ctl[1] = 32'h49;
        rd(1, "ctl_b capture flag");
        check("captured count", crv_b, c0);
        n = int'(rnd() & 32'hffff);
        cw(1, 16'(n));
        wr(1, 8'h01);
        u_pin.fall(1);
        cyc(2);
        check("pin ignored", crv_b, 16'(n));
        rd(1, "ctl_b pin ignored");
        // event counting on pin falls, each fall counted once
        wr(1, 8'h06);
        cyc(1);
        c0 = count_b;
        n = int'(rnd() % 4) + 1;
        repeat (n) u_pin.fall(1);
        cyc(4);
        check("event count", count_b - c0, 16'(n));
        close_out();
    end
endmodule
